/* dv/fws_flash_model.sv */
`timescale 1ns/1ps
`default_nettype none
module fws_flash_model #(
	parameter PROG = 40,
	parameter ERS  = 80,
	parameter WIN  = 120,
	parameter LIM  = 50
) (
	input  wire logic        clock_i,
	input  wire logic        rst_n_i,
	input  wire logic [16:0] addr_i,
	input  wire logic [7:0]  data_i,
	input  wire logic        chip_en_n_i,
	input  wire logic        out_en_n_i,
	input  wire logic        wr_en_n_i,
	output logic      [7:0]  data_o,
	output logic             data_oe_o
);
	logic [7:0]  mem [0:131071];
	logic [7:0]  pd, sect;
	logic [16:0] pa;
	logic [1:0]  st;
	logic        tog, lim, bad, we_q, oe_q, ce_q;
	int          seq, tmr;
	initial for (int i = 0; i < 131072; i++) mem[i] = 8'hff;
	assign data_oe_o = !chip_en_n_i && !out_en_n_i;
	assign data_o = st == 2'h0 ? mem[addr_i] : {st == 2'h1 ? ~pd[7] : 1'b0, tog, lim, 1'b0, st == 2'h3, 3'h0};
	// Strobes are sampled, so edges are seen one clock late; the host holds them long enough.
	always @(posedge clock_i) begin
		we_q <= wr_en_n_i;
		oe_q <= out_en_n_i;
		ce_q <= chip_en_n_i;
		if (!rst_n_i) begin
			st <= 2'h0;
			seq <= 0;
			lim <= 1'b0;
			tog <= 1'b0;
			tmr <= 0;
		end else begin
			if (out_en_n_i && !oe_q && !ce_q && st != 2'h0)
				tog <= ~tog;
			if (tmr > 0)
				tmr <= tmr - 1;
			if (tmr == 1 && st == 2'h1) begin
				if (bad)
					lim <= 1'b1;
				else begin
					mem[pa] <= pd;
					st <= 2'h0;
				end
			end
			if (tmr == 1 && st == 2'h2) begin
				st <= 2'h3;
				tmr <= ERS;
			end
			if (tmr == 1 && st == 2'h3) begin
				for (int i = 0; i < 131072; i++) if (sect[i[16:14]]) mem[i] <= 8'hff;
				st <= 2'h0;
			end
			if (wr_en_n_i && !we_q && !ce_q) begin
				if (lim && data_i == 8'hf0) begin
					st <= 2'h0;
					lim <= 1'b0;
				end else if (st == 2'h2 && data_i == 8'h30) begin
					sect[addr_i[16:14]] <= 1'b1;
					tmr <= WIN;
				end else if (st == 2'h0) begin
					case (seq)
					0: seq <= addr_i == 17'h00555 && data_i == 8'haa ? 1 : 0;
					1: seq <= data_i == 8'h55 ? 2 : 0;
					2: seq <= data_i == 8'ha0 ? 3 : data_i == 8'h80 ? 4 : 0;
					3: begin
						pa <= addr_i;
						pd <= data_i;
						bad <= |(~mem[addr_i] & data_i);
						tmr <= |(~mem[addr_i] & data_i) ? LIM : PROG;
						st <= 2'h1;
						seq <= 0;
					end
					4: seq <= data_i == 8'haa ? 5 : 0;
					5: seq <= data_i == 8'h55 ? 6 : 0;
					default: begin
						if (data_i == 8'h30) begin
							st <= 2'h2;
							sect <= 8'h01 << addr_i[16:14];
							tmr <= WIN;
						end
						seq <= 0;
					end
					endcase
				end
			end
		end
	end
endmodule // fws_flash_model
`default_nettype wire

/* dv/fws_host_sva.sv */
`timescale 1ns/1ps
`default_nettype none
`include "fws_defs.vh"
module fws_host_sva #(
	parameter ADDR_W = 17
) (
	input wire logic              clock_i,
	input wire logic              rst_n_i,
	input wire logic              req_i,
	input wire logic [1:0]        op_i,
	input wire logic [ADDR_W-1:0] addr_i,
	input wire logic [7:0]        data_i,
	input wire logic [7:0]        data_bus_byte_i,
	input wire logic              busy_o,
	input wire logic              done_o,
	input wire logic [1:0]        status_o,
	input wire logic [7:0]        rdata_o,
	input wire logic [ADDR_W-1:0] addr_o,
	input wire logic [7:0]        data_bus_byte_o,
	input wire logic              data_bus_byte_oe_o,
	input wire logic              chip_en_n_o,
	input wire logic              out_en_n_o,
	input wire logic              wr_en_n_o
);
	logic f0_r;
	// A program datum of f0 also sets this, so the check is only one-sided.
	always @(posedge clock_i) begin
		if (!rst_n_i || (req_i && !busy_o))
			f0_r <= 1'b0;
		else if (!wr_en_n_o && data_bus_byte_oe_o && data_bus_byte_o == 8'hf0)
			f0_r <= 1'b1;
	end
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);
	idle_pins_a: assert property (!busy_o && !done_o |-> chip_en_n_o && wr_en_n_o && out_en_n_o)
		else $error("strobe active while idle");
	done_pulse_a: assert property (done_o |=> !done_o) else $error("done longer than one cycle");
	done_idle_a: assert property (done_o |=> !busy_o) else $error("busy after done");
	accept_req_a: assert property (req_i && !busy_o && !done_o |=> busy_o) else $error("request not taken");
	no_fight_a: assert property (data_bus_byte_oe_o |-> out_en_n_o) else $error("drives bus while reading");
	one_strobe_a: assert property (wr_en_n_o || out_en_n_o) else $error("read and write together");
	chip_sel_a: assert property (!wr_en_n_o || !out_en_n_o |-> !chip_en_n_o) else $error("strobe without select");
	// The strobe falls on the accepting edge and rises when the counter reaches the strobe count, five samples low.
	wr_width_a: assert property ($fell(wr_en_n_o) |-> !wr_en_n_o [*5] ##1 wr_en_n_o) else $error("write width");
	rd_width_a: assert property ($fell(out_en_n_o) |-> !out_en_n_o [*5] ##1 out_en_n_o)
		else $error("read width");
	fail_reset_a: assert property (done_o && status_o == `FWS_ST_FAIL |-> f0_r)
		else $error("failure without reset write");
endmodule // fws_host_sva
bind fws_host fws_host_sva #(.ADDR_W(ADDR_W)) u_sva (.clock_i(clock_i), .rst_n_i(rst_n_i), .req_i(req_i),
	.op_i(op_i), .addr_i(addr_i), .data_i(data_i), .data_bus_byte_i(data_bus_byte_i), .busy_o(busy_o),
	.done_o(done_o), .status_o(status_o), .rdata_o(rdata_o), .addr_o(addr_o), .data_bus_byte_o(data_bus_byte_o),
	.data_bus_byte_oe_o(data_bus_byte_oe_o), .chip_en_n_o(chip_en_n_o), .out_en_n_o(out_en_n_o),
	.wr_en_n_o(wr_en_n_o));
`default_nettype wire

/* dv/test_fws_host.sv */
`timescale 1ns/1ps
`default_nettype none
`include "fws_defs.vh"
module test_fws_host;
	logic        clk = 0, rst_n = 0, req = 0, hoe, fo, ce_n, oe_n, we_n, busy, done;
	logic [1:0]  op = 0, st, e;
	logic [16:0] addr = 0, ha, a;
	logic [7:0]  data = 0, hd, fd, rd, d, old, last = 0;
	int          n_fail = 0, checks = 0, n, seed = 32'h40d7568f;
	// A released bus shows a changing pattern, never a stale value.
	wire  [7:0]  dq = hoe ? hd : fo ? fd : ~last;
	always #2 clk = ~clk;
	always @(posedge clk) last <= dq;
	fws_host uut (.clock_i(clk), .rst_n_i(rst_n), .req_i(req), .op_i(op), .addr_i(addr), .data_i(data),
		.data_bus_byte_i(dq), .busy_o(busy), .done_o(done), .status_o(st), .rdata_o(rd), .addr_o(ha),
		.data_bus_byte_o(hd), .data_bus_byte_oe_o(hoe), .chip_en_n_o(ce_n), .out_en_n_o(oe_n), .wr_en_n_o(we_n));
	fws_flash_model m (.clock_i(clk), .rst_n_i(rst_n), .addr_i(ha), .data_i(dq), .chip_en_n_i(ce_n),
		.out_en_n_i(oe_n), .wr_en_n_i(we_n), .data_o(fd), .data_oe_o(fo));
	task end_of_test;
		if (n_fail == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task chk_st(input logic [1:0] g, input logic [1:0] x);
		checks++;
		if (g !== x) begin
			n_fail++;
			$display("[ERR] %0t status %h not %h", $time, g, x);
		end
	endtask
	task chk_d(input logic [7:0] g, input logic [7:0] x);
		checks++;
		if (g !== x) begin
			n_fail++;
			$display("[ERR] %0t data %h not %h", $time, g, x);
		end
	endtask
	task run(input logic [1:0] o, input logic [16:0] ad, input logic [7:0] dt);
		op = o;
		addr = ad;
		data = dt;
		req = 1'b1;
		@(posedge clk) #1 req = 1'b0;
		n = 0;
		while (done !== 1'b1 && n < 9000) begin
			@(posedge clk) #1 n++;
		end
		if (n >= 9000)
			n_fail++;
		@(posedge clk) #1;
	endtask
	function logic [1:0] exp_prog(input logic [7:0] o, input logic [7:0] x);
		return |(~o & x) ? `FWS_ST_FAIL : `FWS_ST_OK;
	endfunction
	initial begin
		repeat (8) @(posedge clk);
		#1 rst_n = 1'b1;
		@(posedge clk) #1;
		for (int i = 0; i < 14; i++) begin
			a = 17'h01230 | ($random(seed) & 17'h7);
			d = i == 0 ? 8'h0f : i == 1 ? 8'hf0 : $random(seed);
			a = i < 2 ? 17'h01230 : a;
			old = m.mem[a];
			run(`FWS_OP_PROGRAM, a, d);
			chk_st(st, exp_prog(old, d));
			chk_d(m.mem[a], old & (exp_prog(old, d) === `FWS_ST_OK ? d : 8'hff));
			chk_d({7'h0, m.lim}, 8'h00);
			if (st === `FWS_ST_OK)
				chk_d(rd, d);
			run(`FWS_OP_READ, a, 8'h00);
			chk_d(rd, m.mem[a]);
		end
		m.mem[17'h04001] = 8'h00;
		m.mem[17'h08002] = 8'h00;
		run(`FWS_OP_ERASE_SECT, 17'h04000, 8'h00);
		chk_st(st, `FWS_ST_OK);
		e = m.st == 2'h2 ? `FWS_ST_OK : `FWS_ST_LATE;
		run(`FWS_OP_ERASE_ADD, 17'h08000, 8'h00);
		chk_st(st, e);
		n = 0;
		while (m.st != 2'h0 && n < 3000) begin
			@(posedge clk) #1 n++;
		end
		run(`FWS_OP_READ, 17'h04001, 8'h00);
		chk_d(rd, 8'hff);
		run(`FWS_OP_READ, 17'h08002, 8'h00);
		chk_d(rd, e === `FWS_ST_OK ? 8'hff : 8'h00);
		run(`FWS_OP_ERASE_ADD, 17'h0c000, 8'h00);
		chk_st(st, `FWS_ST_LATE);
		end_of_test;
	end
	initial begin
		#200000;
		n_fail++;
		end_of_test;
	end
endmodule // test_fws_host
`default_nettype wire

/* verilog/fws_bus_cycle.v */
`timescale 1ns/1ps
`default_nettype none
`include "fws_defs.vh"
// One bus cycle on the flash pins: strobes held for STROBE_CYC plus one clocks, data sampled after two flops.
module fws_bus_cycle #(
	parameter ADDR_W = 17
) (
	input  wire              clock_i,
	input  wire              rst_n_i,
	input  wire              start_i,
	input  wire              write_i,
	input  wire [ADDR_W-1:0] addr_i,
	input  wire [7:0]        wdata_i,
	input  wire [7:0]        data_bus_byte_i,
	output reg               done_o,
	output reg  [7:0]        rdata_o,
	output reg  [ADDR_W-1:0] addr_o,
	output reg  [7:0]        data_bus_byte_o,
	output reg               data_bus_byte_oe_o,
	output reg               chip_en_n_o,
	output reg               out_en_n_o,
	output reg               wr_en_n_o
);
	reg [7:0] sync1_r;
	reg [7:0] sync2_r;
	reg [3:0] cnt_r;
	reg       busy_r;
	reg       wr_r;
	always @(posedge clock_i) begin
		if (!rst_n_i) begin
			sync1_r            <= 8'h00;
			sync2_r            <= 8'h00;
			cnt_r              <= 4'h0;
			busy_r             <= 1'b0;
			wr_r               <= 1'b0;
			done_o             <= 1'b0;
			rdata_o            <= 8'h00;
			addr_o             <= {ADDR_W{1'b0}};
			data_bus_byte_o    <= 8'h00;
			data_bus_byte_oe_o <= 1'b0;
			chip_en_n_o        <= 1'b1;
			out_en_n_o         <= 1'b1;
			wr_en_n_o          <= 1'b1;
		end else begin
			sync1_r <= data_bus_byte_i;
			sync2_r <= sync1_r;
			done_o  <= 1'b0;
			if (start_i && !busy_r) begin
				busy_r             <= 1'b1;
				wr_r               <= write_i;
				cnt_r              <= 4'h0;
				addr_o             <= addr_i;
				data_bus_byte_o    <= wdata_i;
				data_bus_byte_oe_o <= write_i;
				chip_en_n_o        <= 1'b0;
				out_en_n_o         <= write_i;
				wr_en_n_o          <= !write_i;
			end else if (busy_r) begin
				cnt_r <= cnt_r + 4'h1;
				// Strobes release first; the sample waits two more clocks for the synchroniser.
				if (cnt_r == `FWS_STROBE_CYC + 2) begin
					busy_r <= 1'b0;
					done_o <= 1'b1;
					if (!wr_r)
						rdata_o <= sync2_r;
				end else if (cnt_r == `FWS_STROBE_CYC) begin
					chip_en_n_o        <= 1'b1;
					out_en_n_o         <= 1'b1;
					wr_en_n_o          <= 1'b1;
				end else if (cnt_r == `FWS_STROBE_CYC + 1) begin
					data_bus_byte_oe_o <= 1'b0;
				end
			end
		end
	end
endmodule // fws_bus_cycle
`default_nettype wire

/* verilog/fws_defs.vh */
// Behaviour
// - Host reads the full byte twice and compares the toggle bit of both reads.
// - Still toggling with limit bit high: host repeats the toggle comparison.
// - Toggling on that recheck means failure; host writes the reset command.
// - Polling broken off while toggling restarts from the first pair of reads.
// - After any limit failure the host issues reset; device returns to array reads.
// - Host may skip the timer bit only if added commands come under 50 us apart.
// - Host confirms acceptance by toggle, then checks timer bit around each added erase (this host reads it only before each added sector).
// - Timer bit already high after an added erase means it may be lost.
// - Host presents a valid address when reading status.
// - Reset is one write of f0 to any address; device resumes array reads.
`ifndef FWS_DEFS_VH
`define FWS_DEFS_VH
`define FWS_CMD_RESET     8'hf0
`define FWS_CMD_UNLOCK1   8'haa
`define FWS_CMD_UNLOCK2   8'h55
`define FWS_CMD_PROGRAM   8'ha0
`define FWS_CMD_ERASE     8'h80
`define FWS_CMD_SECTOR    8'h30
`define FWS_ADDR_UNLOCK1  17'h00555
`define FWS_ADDR_UNLOCK2  17'h002aa
`define FWS_TOGGLE_POS    6
`define FWS_LIMIT_POS     5
`define FWS_TIMER_POS     3
`define FWS_OP_PROGRAM    2'h0
`define FWS_OP_ERASE_SECT 2'h1
`define FWS_OP_ERASE_ADD  2'h2
`define FWS_OP_READ       2'h3
`define FWS_ST_OK         2'h0
`define FWS_ST_FAIL       2'h1
`define FWS_ST_LATE       2'h2
`define FWS_WINDOW_NS     50000
`define FWS_CLK_NS        4
`define FWS_STROBE_CYC    4
`endif

/* verilog/fws_host.v */
`timescale 1ns/1ps
`default_nettype none
`include "fws_defs.vh"
// Host-side flash write controller: issues program and sector-erase sequences, then polls status.
module fws_host #(
	parameter ADDR_W    = 17,
	parameter WINDOW_NS = `FWS_WINDOW_NS,
	parameter MAX_POLLS = 65535
) (
	input  wire              clock_i,
	input  wire              rst_n_i,
	input  wire              req_i,
	input  wire [1:0]        op_i,
	input  wire [ADDR_W-1:0] addr_i,
	input  wire [7:0]        data_i,
	input  wire [7:0]        data_bus_byte_i,
	output reg               busy_o,
	output reg               done_o,
	output reg  [1:0]        status_o,
	output reg  [7:0]        rdata_o,
	output wire [ADDR_W-1:0] addr_o,
	output wire [7:0]        data_bus_byte_o,
	output wire              data_bus_byte_oe_o,
	output wire              chip_en_n_o,
	output wire              out_en_n_o,
	output wire              wr_en_n_o
);
	localparam [31:0] WINDOW_CYC = WINDOW_NS / `FWS_CLK_NS;
	localparam [7:0] S_IDLE  = 8'h01;
	localparam [7:0] S_WRITE = 8'h02;
	localparam [7:0] S_READ1 = 8'h04;
	localparam [7:0] S_READ2 = 8'h08;
	localparam [7:0] S_RECHK = 8'h10;
	localparam [7:0] S_RESET = 8'h20;
	localparam [7:0] S_TIMER = 8'h40;
	localparam [7:0] S_DONE  = 8'h80;

	reg [7:0]        state_r;
	reg [2:0]        step_r;
	reg [2:0]        nsteps_r;
	reg [1:0]        op_r;
	reg [ADDR_W-1:0] addr_r;
	reg [7:0]        data_r;
	reg [7:0]        first_r;
	reg              recheck_r;
	reg              pre_timer_r;
	reg [15:0]       polls_r;
	reg              start_r;
	reg              cyc_wr_r;
	reg [ADDR_W-1:0] cyc_addr_r;
	reg [7:0]        cyc_data_r;
	wire             cyc_done;
	wire [7:0]       cyc_rdata;

	function [ADDR_W+7:0] seq_word;
		input [1:0] op;
		input [2:0] step;
		input [ADDR_W-1:0] a;
		input [7:0] d;
		begin
			case (step)
			3'd0: seq_word = {`FWS_ADDR_UNLOCK1, `FWS_CMD_UNLOCK1};
			3'd1: seq_word = {`FWS_ADDR_UNLOCK2, `FWS_CMD_UNLOCK2};
			3'd2: seq_word = {`FWS_ADDR_UNLOCK1, (op == `FWS_OP_PROGRAM) ? `FWS_CMD_PROGRAM : `FWS_CMD_ERASE};
			3'd3: seq_word = (op == `FWS_OP_PROGRAM) ? {a, d} : {`FWS_ADDR_UNLOCK1, `FWS_CMD_UNLOCK1};
			3'd4: seq_word = {`FWS_ADDR_UNLOCK2, `FWS_CMD_UNLOCK2};
			default: seq_word = {a, `FWS_CMD_SECTOR};
			endcase
		end
	endfunction

	function toggled;
		input [7:0] a;
		input [7:0] b;
		begin
			toggled = a[`FWS_TOGGLE_POS] ^ b[`FWS_TOGGLE_POS];
		end
	endfunction

	fws_bus_cycle #(.ADDR_W(ADDR_W)) u_cyc (
		.clock_i            (clock_i),
		.rst_n_i            (rst_n_i),
		.start_i            (start_r),
		.write_i            (cyc_wr_r),
		.addr_i             (cyc_addr_r),
		.wdata_i            (cyc_data_r),
		.data_bus_byte_i    (data_bus_byte_i),
		.done_o             (cyc_done),
		.rdata_o            (cyc_rdata),
		.addr_o             (addr_o),
		.data_bus_byte_o    (data_bus_byte_o),
		.data_bus_byte_oe_o (data_bus_byte_oe_o),
		.chip_en_n_o        (chip_en_n_o),
		.out_en_n_o         (out_en_n_o),
		.wr_en_n_o          (wr_en_n_o)
	);

	always @(posedge clock_i) begin
		if (!rst_n_i) begin
			state_r     <= S_IDLE;
			step_r      <= 3'd0;
			nsteps_r    <= 3'd0;
			op_r        <= `FWS_OP_READ;
			addr_r      <= {ADDR_W{1'b0}};
			data_r      <= 8'h00;
			first_r     <= 8'h00;
			recheck_r   <= 1'b0;
			pre_timer_r <= 1'b0;
			polls_r     <= 16'h0000;
			start_r     <= 1'b0;
			cyc_wr_r    <= 1'b0;
			cyc_addr_r  <= {ADDR_W{1'b0}};
			cyc_data_r  <= 8'h00;
			busy_o      <= 1'b0;
			done_o      <= 1'b0;
			status_o    <= `FWS_ST_OK;
			rdata_o     <= 8'h00;
		end else begin
			start_r <= 1'b0;
			done_o  <= 1'b0;
			case (state_r)
			S_IDLE: begin
				if (req_i) begin
					busy_o    <= 1'b1;
					op_r      <= op_i;
					addr_r    <= addr_i;
					data_r    <= data_i;
					step_r    <= 3'd0;
					polls_r   <= 16'h0000;
					recheck_r <= 1'b0;
					status_o  <= `FWS_ST_OK;
					start_r   <= 1'b1;
					cyc_addr_r <= addr_i;
					if (op_i == `FWS_OP_READ) begin
						cyc_wr_r <= 1'b0;
						state_r  <= S_READ2;
					end else if (op_i == `FWS_OP_ERASE_ADD) begin
						// The window is checked before each added sector.
						cyc_wr_r <= 1'b0;
						state_r  <= S_TIMER;
					end else begin
						cyc_wr_r   <= 1'b1;
						{cyc_addr_r, cyc_data_r} <= seq_word(op_i, 3'd0, addr_i, data_i);
						nsteps_r   <= (op_i == `FWS_OP_PROGRAM) ? 3'd4 : 3'd6;
						state_r    <= S_WRITE;
					end
				end
			end
			S_TIMER: if (cyc_done) begin
				if (cyc_rdata[`FWS_TIMER_POS]) begin
					status_o <= `FWS_ST_LATE;
					state_r  <= S_DONE;
				end else begin
					// An added sector needs only the final sector cycle.
					cyc_wr_r   <= 1'b1;
					cyc_addr_r <= addr_r;
					cyc_data_r <= `FWS_CMD_SECTOR;
					step_r     <= 3'd5;
					nsteps_r   <= 3'd6;
					start_r    <= 1'b1;
					state_r    <= S_WRITE;
				end
			end
			S_WRITE: if (cyc_done) begin
				if (step_r + 3'd1 == nsteps_r) begin
					cyc_wr_r   <= 1'b0;
					cyc_addr_r <= addr_r;
					start_r    <= 1'b1;
					recheck_r  <= 1'b0;
					state_r    <= S_READ1;
				end else begin
					step_r <= step_r + 3'd1;
					{cyc_addr_r, cyc_data_r} <= seq_word(op_r, step_r + 3'd1, addr_r, data_r);
					start_r <= 1'b1;
				end
			end
			S_READ1: if (cyc_done) begin
				first_r <= cyc_rdata;
				start_r <= 1'b1;
				state_r <= S_READ2;
			end
			S_READ2: if (cyc_done) begin
				if (op_r == `FWS_OP_READ) begin
					rdata_o <= cyc_rdata;
					state_r <= S_DONE;
				end else if (!toggled(first_r, cyc_rdata)) begin
					// Finished; a plain read of the target follows.
					op_r    <= `FWS_OP_READ;
					start_r <= 1'b1;
					state_r <= S_READ2;
					if (recheck_r)
						status_o <= `FWS_ST_OK;
				end else if (recheck_r) begin
					status_o <= `FWS_ST_FAIL;
					cyc_wr_r   <= 1'b1;
					cyc_data_r <= `FWS_CMD_RESET;
					start_r    <= 1'b1;
					state_r    <= S_RESET;
				end else if (cyc_rdata[`FWS_LIMIT_POS]) begin
					recheck_r <= 1'b1;
					first_r   <= cyc_rdata;
					start_r   <= 1'b1;
					state_r   <= S_READ2;
				end else begin
					// Poll budget exhausted counts as failure; a fresh poll always restarts with a pair.
					polls_r <= polls_r + 16'h0001;
					if (polls_r == MAX_POLLS[15:0]) begin
						status_o   <= `FWS_ST_FAIL;
						cyc_wr_r   <= 1'b1;
						cyc_data_r <= `FWS_CMD_RESET;
						start_r    <= 1'b1;
						state_r    <= S_RESET;
					end else begin
						start_r <= 1'b1;
						state_r <= S_READ1;
					end
				end
			end
			S_RESET: if (cyc_done) begin
				cyc_wr_r <= 1'b0;
				state_r  <= S_DONE;
			end
			S_DONE: begin
				busy_o  <= 1'b0;
				done_o  <= 1'b1;
				state_r <= S_IDLE;
			end
			default: state_r <= S_IDLE;
			endcase
		end
	end
	// Window length is kept for software that chooses to pace added sectors under it.
	wire unused_window = |WINDOW_CYC & pre_timer_r;
endmodule // fws_host
`default_nettype wire
